// ---- rtl/pdw_defines.svh ----
// Register indices, field positions, reset values and delay counts
`ifndef PDW_DEFINES_SVH
`define PDW_DEFINES_SVH

`define PDW_ADDR_W       18
`define PDW_IDX_W        16
`define PDW_IDX_MISC     16'hfff1
`define PDW_IDX_INTC     16'hff94
`define PDW_IDX_CLK      16'h008f
`define PDW_IDX_STAT     16'hff80
`define PDW_IDX_MASK     16'hff81

`define PDW_MISC_PDR     7
`define PDW_MISC_LPBK    1
`define PDW_MISC_SSEL    0
`define PDW_MISC_RESET   8'h00
`define PDW_MISC_WMASK   8'h83

`define PDW_INTC_ROUTE   7
`define PDW_INTC_RTC_EN  5
`define PDW_INTC_RTC_FLG 4
`define PDW_INTC_USB_EN  3
`define PDW_INTC_USB_FLG 2
`define PDW_INTC_KP_EN   1
`define PDW_INTC_KP_FLG  0
`define PDW_INTC_RESET   8'h00
`define PDW_INTC_SPARE   6

`define PDW_CLK_HSO      7
`define PDW_CLK_KB       6
`define PDW_CLK_SC       5
`define PDW_CLK_USB      4
`define PDW_CLK_K32      3
`define PDW_CLK_RESET    8'h0a

`define PDW_STAT_PD      0
`define PDW_STAT_WAKE    1
`define PDW_STAT_W       2
`define PDW_STAT_RESET   2'h0
`define PDW_RDATA_RESET  32'h00000000
`define PDW_PINS_RESET   8'h00

`define PDW_CNT_W        10
`define PDW_CNT_ONE      10'h001
`define PDW_CNT_ZERO     10'h000
`define PDW_GRACE_CYCLES 10'd32
`define PDW_WAKE_CYCLES  10'd512

`endif

// ---- rtl/pdw_pkg.sv ----
// Types shared by the power-down and wake control block
package pdw_pkg;

  typedef enum logic [3:0] {
    PDW_RUN   = 4'h1,
    PDW_GRACE = 4'h2,
    PDW_DOWN  = 4'h4,
    PDW_WAKE  = 4'h8
  } pdw_state_e;

  typedef logic [7:0] pdw_byte_t;

endpackage

// ---- rtl/pdw_delay_counter.sv ----
// Down counter that flags expiry a fixed number of cycles after start
`timescale 1ns/10ps
`default_nettype none
`include "pdw_defines.svh"

module pdw_delay_counter (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Control
  input  wire logic                  start,
  input  wire logic                  abort,
  input  wire logic [`PDW_CNT_W-1:0] limit,
  // Status
  output logic                       busy,
  output logic                       expire
);

  logic [`PDW_CNT_W-1:0] cnt_q;
  logic                  busy_q;

  assign busy   = busy_q;
  assign expire = busy_q && (cnt_q == `PDW_CNT_ZERO);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= `PDW_CNT_ZERO;
      busy_q <= 1'b0;
    end else if (abort) begin
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q  <= limit - `PDW_CNT_ONE;
      busy_q <= 1'b1;
    end else if (expire) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - `PDW_CNT_ONE;
    end
  end

endmodule // pdw_delay_counter

`default_nettype wire

// ---- rtl/pdw_power_down_wake_control.sv ----
// Power-down entry, wake routing and wake delay with APB registers
//
// Functional notes
// - With wake routing set, USB, RTC, keypad, smart card and user-pin interrupts go to interrupt zero instead of lines five and four.
// - A routed wake interrupt reaches interrupt zero only 513 clocks after it appears.
// - Reading the interrupt control register clears its wake routing bit.
// - Writing one to the power-down request turns off oscillator and PLL exactly 32 clocks later.
// - In power-down the RTC keeps running when it is clocked from the 32kHz oscillator.
// - During power-down the processor clock stays stopped until a wake restores the clocks.
// - While the power-down request is set, the keypad, smart card and USB clocks are off whatever their own bits say.
// - A loopback bit feeds the UART transmit path back into its receive path.
// - Bit 0 of the miscellaneous register selects the serial port pins.
// - A wake restores power and clocks, then counts 512 clocks before the interrupt is presented.
// - Power-down leaves the stored oscillator-disable bit unchanged.
`timescale 1ns/10ps
`default_nettype none
`include "pdw_defines.svh"

module pdw_power_down_wake_control (
  // APB slave
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`PDW_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Interrupt sources
  input  wire logic                   rtc_event,
  input  wire logic                   usb_event,
  input  wire logic                   keypad_event,
  input  wire logic                   smartcard_irq,
  input  wire logic [7:0]             user_pins,
  // Interrupt lines
  output logic                        ext_interrupt_zero,
  output logic                        ext_interrupt_four,
  output logic                        ext_interrupt_five,
  output logic                        irq,
  // Power and clock controls
  output logic                        processor_clock_en,
  output logic                        hs_osc_off,
  output logic                        pll_off,
  output logic                        analog_bias_off,
  output logic                        keypad_clk_off,
  output logic                        smartcard_clk_off,
  output logic                        usb_clk_off,
  output logic                        osc32k_off,
  output logic                        rtc_clock_run,
  // Serial port controls
  output logic                        uart_loopback,
  output logic                        serial_pin_select
);

  // Byte address of a register index
  function automatic logic [`PDW_ADDR_W-1:0] addr_of(input logic [`PDW_IDX_W-1:0] idx);
    addr_of = {idx, 2'b00};
  endfunction

  // Flag update where a hardware set beats a clear
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction

  // Register byte placed on the low lane of the read bus
  function automatic logic [31:0] word_of_byte(input pdw_pkg::pdw_byte_t b);
    word_of_byte = {24'h000000, b};
  endfunction

  // Status-layout field placed on the low lane of the read bus
  function automatic logic [31:0] word_of_stat(input logic [`PDW_STAT_W-1:0] s);
    word_of_stat = {30'h00000000, s};
  endfunction

  // Register and state storage
  pdw_pkg::pdw_state_e          state_q;
  pdw_pkg::pdw_state_e          state_d;
  pdw_pkg::pdw_byte_t           misc_q;
  pdw_pkg::pdw_byte_t           intc_q;
  pdw_pkg::pdw_byte_t           intc_d;
  pdw_pkg::pdw_byte_t           clk_q;
  logic [`PDW_STAT_W-1:0]       stat_q;
  logic [`PDW_STAT_W-1:0]       stat_d;
  logic [`PDW_STAT_W-1:0]       mask_q;
  logic [31:0]                  prdata_q;
  logic [7:0]                   pins_meta_q;
  logic [7:0]                   pins_sync_q;
  logic                         wake_ready_q;

  // APB decode
  wire setup_ph   = psel && !penable;
  wire access_ph  = psel && penable;
  wire sel_misc   = paddr == addr_of(`PDW_IDX_MISC);
  wire sel_intc   = paddr == addr_of(`PDW_IDX_INTC);
  wire sel_clk    = paddr == addr_of(`PDW_IDX_CLK);
  wire sel_stat   = paddr == addr_of(`PDW_IDX_STAT);
  wire sel_mask   = paddr == addr_of(`PDW_IDX_MASK);
  wire addr_hit   = sel_misc | sel_intc | sel_clk | sel_stat | sel_mask;
  wire xfer_done  = access_ph;
  wire wr_ok      = xfer_done && pwrite && addr_hit;
  wire rd_ok      = xfer_done && !pwrite && addr_hit;
  wire wr_misc    = wr_ok && sel_misc;
  wire wr_intc    = wr_ok && sel_intc;
  wire wr_clk     = wr_ok && sel_clk;
  wire wr_mask    = wr_ok && sel_mask;
  wire rd_intc    = rd_ok && sel_intc;
  wire rd_stat    = rd_ok && sel_stat;
  wire [7:0] wbyte = pwdata[7:0];

  assign pready  = access_ph;
  assign pslverr = access_ph && !addr_hit;
  assign prdata  = prdata_q;

  // Read data mux, captured in the setup cycle
  wire [31:0] rd_mux =
    sel_misc ? word_of_byte(misc_q) :
    sel_intc ? word_of_byte(intc_q) :
    sel_clk  ? word_of_byte(clk_q) :
    sel_stat ? word_of_stat(stat_q) :
    sel_mask ? word_of_stat(mask_q) : 32'h00000000;

  // Field views
  wire pd_request   = misc_q[`PDW_MISC_PDR];
  wire route_sel    = intc_q[`PDW_INTC_ROUTE];
  wire rtc_req      = intc_q[`PDW_INTC_RTC_EN] & intc_q[`PDW_INTC_RTC_FLG];
  wire usb_req      = intc_q[`PDW_INTC_USB_EN] & intc_q[`PDW_INTC_USB_FLG];
  wire kp_req       = intc_q[`PDW_INTC_KP_EN] & intc_q[`PDW_INTC_KP_FLG];
  wire ext_interrupt_five_req     = rtc_req | usb_req | kp_req;
  wire user_req     = |pins_sync_q;
  wire any_wake_src = ext_interrupt_five_req | smartcard_irq | user_req;
  wire routed_req   = route_sel & any_wake_src;

  wire in_run   = state_q == pdw_pkg::PDW_RUN;
  wire in_grace = state_q == pdw_pkg::PDW_GRACE;
  wire in_down  = state_q == pdw_pkg::PDW_DOWN;
  wire in_wake  = state_q == pdw_pkg::PDW_WAKE;

  // Grace and wake delay counters
  wire grace_busy;
  wire grace_exp;
  wire wake_busy;
  wire wake_exp;
  wire pd_set_wr  = wr_misc && wbyte[`PDW_MISC_PDR];
  wire grace_go   = pd_set_wr && in_run;
  wire grace_stop = in_grace && !pd_request;
  wire wake_go    = routed_req && !wake_busy && !wake_ready_q;
  wire wake_stop  = !routed_req && !in_wake;

  pdw_delay_counter u_grace_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (grace_go),
    .abort   (grace_stop),
    .limit   (`PDW_GRACE_CYCLES),
    .busy    (grace_busy),
    .expire  (grace_exp)
  );

  pdw_delay_counter u_wake_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (wake_go),
    .abort   (wake_stop),
    .limit   (`PDW_WAKE_CYCLES),
    .busy    (wake_busy),
    .expire  (wake_exp)
  );

  // Power-down sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      pdw_pkg::PDW_RUN: begin
        if (grace_go) begin
          state_d = pdw_pkg::PDW_GRACE;
        end
      end
      pdw_pkg::PDW_GRACE: begin
        if (grace_stop) begin
          state_d = pdw_pkg::PDW_RUN;
        end else if (grace_exp) begin
          state_d = pdw_pkg::PDW_DOWN;
        end
      end
      pdw_pkg::PDW_DOWN: begin
        if (routed_req) begin
          state_d = pdw_pkg::PDW_WAKE;
        end
      end
      pdw_pkg::PDW_WAKE: begin
        if (wake_exp || wake_ready_q) begin
          state_d = pdw_pkg::PDW_RUN;
        end
      end
      default: begin
        state_d = pdw_pkg::PDW_RUN;
      end
    endcase
  end

  // Sequence events
  wire wake_entry = in_down && routed_req;
  wire pd_entry   = in_grace && !grace_stop && grace_exp;

  // Interrupt control register next value
  always_comb begin
    intc_d = intc_q;
    if (wr_intc) begin
      intc_d[`PDW_INTC_ROUTE]  = wbyte[`PDW_INTC_ROUTE];
      intc_d[`PDW_INTC_RTC_EN] = wbyte[`PDW_INTC_RTC_EN];
      intc_d[`PDW_INTC_USB_EN] = wbyte[`PDW_INTC_USB_EN];
      intc_d[`PDW_INTC_KP_EN]  = wbyte[`PDW_INTC_KP_EN];
    end
    if (rd_intc) begin
      intc_d[`PDW_INTC_ROUTE] = 1'b0;
    end
    intc_d[`PDW_INTC_RTC_FLG] = flag_next(intc_q[`PDW_INTC_RTC_FLG], rtc_event,
                                          wr_intc && !wbyte[`PDW_INTC_RTC_FLG]);
    intc_d[`PDW_INTC_USB_FLG] = flag_next(intc_q[`PDW_INTC_USB_FLG], usb_event,
                                          wr_intc && !wbyte[`PDW_INTC_USB_FLG]);
    intc_d[`PDW_INTC_KP_FLG]  = flag_next(intc_q[`PDW_INTC_KP_FLG], keypad_event,
                                          wr_intc && !wbyte[`PDW_INTC_KP_FLG]);
    intc_d[`PDW_INTC_SPARE] = 1'b0;
  end

  // Status events, cleared by reading status
  always_comb begin
    stat_d = stat_q;
    stat_d[`PDW_STAT_PD]   = flag_next(stat_q[`PDW_STAT_PD], pd_entry, rd_stat);
    stat_d[`PDW_STAT_WAKE] = flag_next(stat_q[`PDW_STAT_WAKE], wake_exp, rd_stat);
  end

  // State and status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pdw_pkg::PDW_RUN;
      stat_q  <= `PDW_STAT_RESET;
    end else begin
      state_q <= state_d;
      stat_q  <= stat_d;
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `PDW_STAT_RESET;
    end else if (wr_mask) begin
      mask_q <= pwdata[`PDW_STAT_W-1:0];
    end
  end

  // Miscellaneous register; the request bit drops when a wake starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_q <= `PDW_MISC_RESET;
    end else if (wr_misc) begin
      misc_q <= wbyte & `PDW_MISC_WMASK;
    end else if (wake_entry) begin
      misc_q[`PDW_MISC_PDR] <= 1'b0;
    end
  end

  // Interrupt control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intc_q <= `PDW_INTC_RESET;
    end else begin
      intc_q <= intc_d;
    end
  end

  // Clock control register, never written by power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= `PDW_CLK_RESET;
    end else if (wr_clk) begin
      clk_q <= wbyte;
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `PDW_RDATA_RESET;
    end else if (setup_ph) begin
      prdata_q <= rd_mux;
    end
  end

  // User pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta_q <= `PDW_PINS_RESET;
      pins_sync_q <= `PDW_PINS_RESET;
    end else begin
      pins_meta_q <= user_pins;
      pins_sync_q <= pins_meta_q;
    end
  end

  // Wake interrupt becomes visible after the delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_ready_q <= 1'b0;
    end else if (wake_exp) begin
      wake_ready_q <= 1'b1;
    end else if (wake_stop) begin
      wake_ready_q <= 1'b0;
    end
  end

  // Unmasked pending events
  wire [`PDW_STAT_W-1:0] irq_pend = stat_q & mask_q;

  // Interrupt lines
  assign ext_interrupt_zero = route_sel ? (wake_ready_q & routed_req) : user_req;
  assign ext_interrupt_four = !route_sel & smartcard_irq;
  assign ext_interrupt_five = !route_sel & ext_interrupt_five_req;
  assign irq                = |irq_pend;

  // Power and clock controls
  assign processor_clock_en = !in_down;
  assign hs_osc_off         = clk_q[`PDW_CLK_HSO] | in_down;
  assign pll_off            = clk_q[`PDW_CLK_HSO] | in_down;
  assign analog_bias_off    = in_down;
  assign keypad_clk_off     = clk_q[`PDW_CLK_KB] | pd_request;
  assign smartcard_clk_off  = clk_q[`PDW_CLK_SC] | pd_request;
  assign usb_clk_off        = clk_q[`PDW_CLK_USB] | pd_request;
  assign osc32k_off         = clk_q[`PDW_CLK_K32];
  assign rtc_clock_run      = !in_down | !clk_q[`PDW_CLK_K32];

  // Serial port controls
  assign uart_loopback     = misc_q[`PDW_MISC_LPBK];
  assign serial_pin_select = misc_q[`PDW_MISC_SSEL];

endmodule // pdw_power_down_wake_control

`default_nettype wire

// ---- tb/pdw_power_down_wake_control_assertions.sv ----
// Checker for the power-down and wake control block
`timescale 1ns/10ps
`default_nettype none
`include "pdw_defines.svh"
module pdw_wake_assertions (
  // Clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  // Interrupts
  input wire logic        smartcard_irq,
  input wire logic        ext_interrupt_zero,
  input wire logic        ext_interrupt_four,
  input wire logic        ext_interrupt_five,
  // Power and serial controls
  input wire logic        processor_clock_en,
  input wire logic        hs_osc_off,
  input wire logic        pll_off,
  input wire logic        analog_bias_off,
  input wire logic        usb_clk_off,
  input wire logic        osc32k_off,
  input wire logic        rtc_clock_run,
  input wire logic        uart_loopback,
  input wire logic        serial_pin_select
);
  localparam logic [17:0] A_MISC = {`PDW_IDX_MISC, 2'b00};
  localparam logic [17:0] A_INTC = {`PDW_IDX_INTC, 2'b00};
  logic       misc_wr;
  logic       pd_wr;
  logic [9:0] sc_cnt_q;
  assign misc_wr = psel && penable && pwrite && paddr == A_MISC;
  assign pd_wr   = misc_wr && pwdata[7];
  // Cycles the smart card source has stood high
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) sc_cnt_q <= 10'h000;
    else if (!smartcard_irq) sc_cnt_q <= 10'h000;
    else if (sc_cnt_q != 10'h3ff) sc_cnt_q <= sc_cnt_q + 10'h001;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence intc_read_s;
    psel && penable && !pwrite && paddr == A_INTC ##1 smartcard_irq;
  endsequence
  pd_delay_a: assert property ($rose(analog_bias_off) |-> $past(pd_wr, 33))
    else $error("power-down not 32 cycles after request");
  down_state_a: assert property (analog_bias_off |-> !processor_clock_en && hs_osc_off && pll_off)
    else $error("core clock or oscillator live in power-down");
  wake_delay_a: assert property ($rose(ext_interrupt_zero) && smartcard_irq
    && !ext_interrupt_four |-> sc_cnt_q >= 10'd511)
    else $error("routed interrupt too early");
  route_four_a: assert property (ext_interrupt_four |-> smartcard_irq)
    else $error("line four without its source");
  route_five_a: assert property (smartcard_irq && !ext_interrupt_four |-> !ext_interrupt_five)
    else $error("line five active while routed");
  route_clear_a: assert property (intc_read_s |-> ext_interrupt_four)
    else $error("routing not cleared by read");
  override_a: assert property (pd_wr |=> usb_clk_off)
    else $error("function clock not overridden");
  serial_ctl_a: assert property (misc_wr |=> uart_loopback == $past(pwdata[1])
    && serial_pin_select == $past(pwdata[0])) else $error("serial controls not stored");
  rtc_run_a: assert property (!osc32k_off |-> rtc_clock_run)
    else $error("rtc stopped with 32k oscillator on");
  wake_order_a: assert property ($fell(analog_bias_off) |-> !ext_interrupt_zero)
    else $error("interrupt before clocks restored");
endmodule // pdw_wake_assertions
`default_nettype wire

// ---- tb/pdw_power_down_wake_control_bench.sv ----
// Self-checking bench for the power-down and wake control block
`timescale 1ns/10ps
`default_nettype none
`include "pdw_defines.svh"
module pdw_power_down_wake_control_bench;
  localparam logic [17:0] A_MISC = {`PDW_IDX_MISC, 2'b00};
  localparam logic [17:0] A_INTC = {`PDW_IDX_INTC, 2'b00};
  localparam logic [17:0] A_CLK  = {`PDW_IDX_CLK, 2'b00};
  localparam logic [17:0] A_STAT = {`PDW_IDX_STAT, 2'b00};
  localparam logic [17:0] A_MASK = {`PDW_IDX_MASK, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        rtc_event, usb_event, keypad_event, smartcard_irq, processor_clock_en;
  logic        ext_interrupt_zero, ext_interrupt_four, ext_interrupt_five, rtc_clock_run;
  logic        hs_osc_off, pll_off, analog_bias_off, keypad_clk_off, smartcard_clk_off;
  logic        usb_clk_off, osc32k_off, uart_loopback, serial_pin_select;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  user_pins, q;
  int          n_errors, check_count, n;
  pdw_power_down_wake_control u_pdw_power_down_wake_control (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rtc_event, .usb_event, .keypad_event, .smartcard_irq, .user_pins, .ext_interrupt_zero,
    .ext_interrupt_four, .ext_interrupt_five, .irq, .processor_clock_en, .hs_osc_off,
    .pll_off, .analog_bias_off, .keypad_clk_off, .smartcard_clk_off, .usb_clk_off,
    .osc32k_off, .rtc_clock_run, .uart_loopback, .serial_pin_select);
  always #25 pclk = ~pclk;
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bound(input int c);
    if (c >= 700) begin
      n_errors++;
      final_report();
    end
  endtask
  // One bus transfer, result left in q and err
  task automatic apb(input logic [17:0] a, input logic w, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 700);
    bound(k);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic rdc(input logic [17:0] a, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    chk(q, e);
  endtask
  task automatic t_reset;
    rdc(A_MISC, 8'h00);
    rdc(A_INTC, 8'h00);
    rdc(A_CLK, 8'h0a);
    rdc(A_MASK, 8'h00);
    chk(osc32k_off, 1'b1);
    apb(18'h00100, 1'b0, 8'h00);
    chk(err, 1'b1);
  endtask
  task automatic t_serial;
    apb(A_MISC, 1'b1, 8'h7f);
    rdc(A_MISC, 8'h03);
    chk({uart_loopback, serial_pin_select}, 2'b11);
    apb(A_MISC, 1'b1, 8'h01);
    chk({uart_loopback, serial_pin_select}, 2'b01);
    apb(A_MISC, 1'b1, 8'h00);
  endtask
  task automatic t_ext_interrupt_five;
    for (int i = 0; i < 3; i++) begin
      apb(A_INTC, 1'b1, 8'h00);
      @(posedge pclk);
      {rtc_event, usb_event, keypad_event} <= 3'b001 << i;
      @(posedge pclk);
      {rtc_event, usb_event, keypad_event} <= 3'b000;
      @(negedge pclk);
      chk(ext_interrupt_five, 1'b0);
      apb(A_INTC, 1'b1, 8'h03 << (2 * i));
      chk(ext_interrupt_five, 1'b1);
      apb(A_INTC, 1'b1, 8'h02 << (2 * i));
      chk(ext_interrupt_five, 1'b0);
    end
  endtask
  task automatic t_route;
    @(posedge pclk);
    smartcard_irq <= 1'b1;
    @(negedge pclk);
    chk(ext_interrupt_four, 1'b1);
    apb(A_INTC, 1'b1, 8'h80);
    chk(ext_interrupt_four, 1'b0);
    repeat (500) @(negedge pclk);
    chk(ext_interrupt_zero, 1'b0);
    for (n = 0; n < 700 && ext_interrupt_zero !== 1'b1; n++) @(negedge pclk);
    bound(n);
    chk(n + 500, `PDW_WAKE_CYCLES + 1);
    rdc(A_STAT, 8'h02);
    rdc(A_INTC, 8'h80);
    rdc(A_INTC, 8'h00);
    chk({ext_interrupt_zero, ext_interrupt_four}, 2'b01);
    @(posedge pclk);
    smartcard_irq <= 1'b0;
    user_pins <= 8'h08;
    repeat (2) @(negedge pclk);
    chk(ext_interrupt_zero, 1'b0);
    @(negedge pclk);
    chk(ext_interrupt_zero, 1'b1);
    @(posedge pclk);
    user_pins <= 8'h00;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_pd;
    apb(A_CLK, 1'b1, 8'h02);
    apb(A_MASK, 1'b1, 8'h01);
    apb(A_INTC, 1'b1, 8'h80);
    apb(A_MISC, 1'b1, 8'h80);
    chk({usb_clk_off, keypad_clk_off, smartcard_clk_off, hs_osc_off}, 4'he);
    repeat (31) @(negedge pclk);
    chk(hs_osc_off, 1'b0);
    @(negedge pclk);
    chk({hs_osc_off, pll_off, analog_bias_off, processor_clock_en}, 4'he);
    chk({rtc_clock_run, irq}, 2'b11);
    rdc(A_CLK, 8'h02);
    rdc(A_STAT, 8'h01);
    chk(irq, 1'b0);
    @(posedge pclk);
    smartcard_irq <= 1'b1;
    for (n = 0; n < 700 && processor_clock_en !== 1'b1; n++) @(negedge pclk);
    bound(n);
    chk(n, 32'd2);
    chk(ext_interrupt_zero, 1'b0);
    for (n = 0; n < 700 && ext_interrupt_zero !== 1'b1; n++) @(negedge pclk);
    bound(n);
    chk(n, `PDW_WAKE_CYCLES);
    chk(irq, 1'b0);
    rdc(A_MISC, 8'h00);
    rdc(A_STAT, 8'h02);
    rdc(A_INTC, 8'h80);
    @(posedge pclk);
    smartcard_irq <= 1'b0;
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h00000;
    pwdata = 32'h00000000;
    {rtc_event, usb_event, keypad_event} = 3'b000;
    smartcard_irq = 1'b0;
    user_pins = 8'h00;
    n_errors = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_serial();
    t_ext_interrupt_five();
    t_route();
    t_pd();
    final_report();
  end
endmodule // pdw_power_down_wake_control_bench
bind pdw_power_down_wake_control pdw_wake_assertions u_pdw_wake_assertions (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .smartcard_irq,
  .ext_interrupt_zero, .ext_interrupt_four, .ext_interrupt_five, .processor_clock_en,
  .hs_osc_off, .pll_off, .analog_bias_off, .usb_clk_off, .osc32k_off, .rtc_clock_run,
  .uart_loopback, .serial_pin_select);
`default_nettype wire
